// >>> hw/pin_synchronizer.sv
// Two-stage synchronizer for a bundle of asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    if (WIDTH < 1) begin : g_width_check
        $error("pin_synchronizer needs WIDTH of at least one.");
    end

    // The first stage feeds the second stage only, so metastability cannot spread.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1_reg <= RESET_VALUE;
            stage2_reg <= RESET_VALUE;
        end else begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

endmodule // pin_synchronizer
`default_nettype wire

// >>> hw/power_state_pkg.sv
// Package with the state codes, carriers and constants of the power state sequencer.
package power_state_pkg;

    localparam int STATE_WIDTH = 6;
    localparam int MESSAGE_WIDTH = 16;

    typedef enum logic [STATE_WIDTH-1:0] {
        ST_NORMAL      = 6'h01,
        ST_AUTO_HALT   = 6'h02,
        ST_QUICK_START = 6'h04,
        ST_DEEP_SLEEP  = 6'h08,
        ST_OFF         = 6'h10,
        ST_SNOOP       = 6'h20
    } power_state_type;

    localparam power_state_type STATE_RESET = ST_NORMAL;

    // Message codes carried in the data phase of the special cycle.
    localparam logic [MESSAGE_WIDTH-1:0] HALT_MESSAGE = 16'h0001;
    localparam logic [MESSAGE_WIDTH-1:0] STOP_GRANT_MESSAGE = 16'h0002;
    localparam logic [MESSAGE_WIDTH-1:0] MESSAGE_RESET = 16'h0000;

    // Input clock is called stopped after this many system cycles without an edge.
    localparam int CLOCK_STOP_CYCLES = 16;

    typedef struct packed {
        logic valid;
        logic [MESSAGE_WIDTH-1:0] message;
    } special_cycle_type;

    localparam special_cycle_type SPECIAL_CYCLE_RESET = '{valid: 1'b0, message: MESSAGE_RESET};

    // Pins from the platform; active-low ones idle high.
    typedef struct packed {
        logic clock_halt_request_n;
        logic deep_idle_request_n;
        logic input_clock_pin;
        logic maskable_irq_line;
        logic nonmaskable_irq;
        logic system_mgmt_irq_n;
        logic warm_restart_n;
        logic reset_n;
        logic power_good;
    } pin_bundle_type;

    localparam pin_bundle_type PINS_RESET = '{
        clock_halt_request_n: 1'b1,
        deep_idle_request_n: 1'b1,
        input_clock_pin: 1'b0,
        maskable_irq_line: 1'b0,
        nonmaskable_irq: 1'b0,
        system_mgmt_irq_n: 1'b1,
        warm_restart_n: 1'b1,
        reset_n: 1'b1,
        power_good: 1'b1
    };

endpackage

// >>> hw/processor_power_state_machine.sv
// Processor power state sequencer with halt and stop-grant special cycle requests.
`timescale 1ns/1ps
`default_nettype none
module processor_power_state_machine #(
    parameter int CLOCK_STOP_CYCLES = power_state_pkg::CLOCK_STOP_CYCLES,
    parameter logic [power_state_pkg::MESSAGE_WIDTH-1:0] HALT_MESSAGE =
        power_state_pkg::HALT_MESSAGE,
    parameter logic [power_state_pkg::MESSAGE_WIDTH-1:0] STOP_GRANT_MESSAGE =
        power_state_pkg::STOP_GRANT_MESSAGE
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic IDLE_INSTRUCTION_I,
    input wire logic SNOOP_EVENT_I,
    input wire logic SNOOP_SERVICED_I,
    input wire logic SPECIAL_CYCLE_DONE_I,
    input wire logic CLOCK_HALT_REQUEST_N_I,
    input wire logic DEEP_IDLE_REQUEST_N_I,
    input wire logic INPUT_CLOCK_PIN_I,
    input wire logic MASKABLE_IRQ_LINE_I,
    input wire logic NONMASKABLE_IRQ_I,
    input wire logic SYSTEM_MGMT_IRQ_N_I,
    input wire logic WARM_RESTART_N_I,
    input wire logic RESET_N_I,
    input wire logic POWER_GOOD_I,
    output logic [power_state_pkg::STATE_WIDTH-1:0] POWER_STATE_O,
    output logic CORE_IDLE_O,
    output logic SPECIAL_CYCLE_VALID_O,
    output logic [power_state_pkg::MESSAGE_WIDTH-1:0] SPECIAL_CYCLE_MESSAGE_O,
    output logic SNOOP_SERVICE_O,
    output logic INPUT_CLOCK_RUNNING_O
);

    localparam int COUNT_WIDTH = $clog2(CLOCK_STOP_CYCLES + 1);
    localparam logic [COUNT_WIDTH-1:0] STOP_LIMIT = COUNT_WIDTH'(CLOCK_STOP_CYCLES);
    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = '0;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE = COUNT_WIDTH'(1);

    if (CLOCK_STOP_CYCLES < 2) begin : g_stop_check
        $error("CLOCK_STOP_CYCLES must be at least two system cycles.");
    end

    if (HALT_MESSAGE == STOP_GRANT_MESSAGE) begin : g_message_check
        $error("Halt and stop-grant messages must differ.");
    end

    power_state_pkg::pin_bundle_type pins_async;
    power_state_pkg::pin_bundle_type pins;
    power_state_pkg::power_state_type state_reg;
    power_state_pkg::power_state_type state_next;
    power_state_pkg::special_cycle_type cycle_reg;
    logic core_idle_reg;
    logic core_idle_next;
    logic halt_pending_reg;
    logic stop_grant_done_reg;
    logic clock_level_reg;
    logic [COUNT_WIDTH-1:0] quiet_count_reg;
    logic clock_running;
    logic clock_halt_active;
    logic deep_idle_active;
    logic halt_break;
    logic cycle_finished;
    logic enter_auto_halt;
    logic launch_stop_grant;
    logic leave_stop_grant_window;

    function automatic logic is_stop_grant_window(input power_state_pkg::power_state_type st);
        is_stop_grant_window = (st == power_state_pkg::ST_NORMAL) ||
                               (st == power_state_pkg::ST_AUTO_HALT);
    endfunction

    assign pins_async = '{
        clock_halt_request_n: CLOCK_HALT_REQUEST_N_I,
        deep_idle_request_n: DEEP_IDLE_REQUEST_N_I,
        input_clock_pin: INPUT_CLOCK_PIN_I,
        maskable_irq_line: MASKABLE_IRQ_LINE_I,
        nonmaskable_irq: NONMASKABLE_IRQ_I,
        system_mgmt_irq_n: SYSTEM_MGMT_IRQ_N_I,
        warm_restart_n: WARM_RESTART_N_I,
        reset_n: RESET_N_I,
        power_good: POWER_GOOD_I
    };

    pin_synchronizer #(
        .WIDTH($bits(power_state_pkg::pin_bundle_type)),
        .RESET_VALUE(power_state_pkg::PINS_RESET)
    ) u_pin_sync (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .async_i(pins_async),
        .sync_o(pins)
    );

    assign clock_halt_active = !pins.clock_halt_request_n;
    assign deep_idle_active = !pins.deep_idle_request_n;
    assign halt_break = pins.maskable_irq_line || pins.nonmaskable_irq ||
                        !pins.system_mgmt_irq_n || !pins.warm_restart_n ||
                        !pins.reset_n;

    // The input clock is far slower to be trusted than sampled, so it is judged by
    // edge activity; a stop is only seen after the quiet window, which delays Deep Sleep.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            clock_level_reg <= 1'b0;
            quiet_count_reg <= COUNT_ZERO;
        end else begin
            clock_level_reg <= pins.input_clock_pin;
            if (clock_level_reg != pins.input_clock_pin) begin
                quiet_count_reg <= COUNT_ZERO;
            end else if (quiet_count_reg != STOP_LIMIT) begin
                quiet_count_reg <= quiet_count_reg + COUNT_ONE;
            end
        end
    end

    assign clock_running = (quiet_count_reg != STOP_LIMIT);

    assign cycle_finished = cycle_reg.valid && SPECIAL_CYCLE_DONE_I;
    assign enter_auto_halt = (state_reg == power_state_pkg::ST_NORMAL) && IDLE_INSTRUCTION_I &&
                             pins.power_good;
    // A stop-grant starts only on an idle bus, so the cycle that finishes a grant
    // cannot launch the same grant again before the done flag is seen.
    assign launch_stop_grant = is_stop_grant_window(state_reg) && clock_halt_active &&
                               !stop_grant_done_reg && !halt_pending_reg &&
                               !cycle_reg.valid;
    assign leave_stop_grant_window = !is_stop_grant_window(state_next);

    always_comb begin
        state_next = state_reg;
        core_idle_next = core_idle_reg;
        if (!pins.power_good) begin
            state_next = power_state_pkg::ST_OFF;
            core_idle_next = 1'b0;
        end else begin
            unique case (state_reg)
                power_state_pkg::ST_NORMAL: begin
                    if (clock_halt_active && stop_grant_done_reg) begin
                        state_next = power_state_pkg::ST_QUICK_START;
                    end else if (IDLE_INSTRUCTION_I) begin
                        state_next = power_state_pkg::ST_AUTO_HALT;
                        core_idle_next = 1'b1;
                    end
                end
                power_state_pkg::ST_AUTO_HALT: begin
                    if (halt_break) begin
                        state_next = power_state_pkg::ST_NORMAL;
                        core_idle_next = 1'b0;
                    end else if (clock_halt_active && stop_grant_done_reg) begin
                        state_next = power_state_pkg::ST_QUICK_START;
                    end else if (SNOOP_EVENT_I) begin
                        state_next = power_state_pkg::ST_SNOOP;
                    end
                end
                power_state_pkg::ST_QUICK_START: begin
                    if (!clock_halt_active) begin
                        state_next = core_idle_reg ? power_state_pkg::ST_AUTO_HALT :
                                                     power_state_pkg::ST_NORMAL;
                    end else if (deep_idle_active && !clock_running) begin
                        state_next = power_state_pkg::ST_DEEP_SLEEP;
                    end else if (SNOOP_EVENT_I) begin
                        state_next = power_state_pkg::ST_SNOOP;
                    end
                end
                power_state_pkg::ST_DEEP_SLEEP: begin
                    // Clock-halt changes alone do not move Deep Sleep.
                    if (!deep_idle_active && clock_running) begin
                        state_next = power_state_pkg::ST_QUICK_START;
                    end
                end
                power_state_pkg::ST_SNOOP: begin
                    if (SNOOP_SERVICED_I) begin
                        state_next = core_idle_reg ? power_state_pkg::ST_AUTO_HALT :
                                                     power_state_pkg::ST_QUICK_START;
                    end
                end
                power_state_pkg::ST_OFF: begin
                    if (pins.reset_n) begin
                        state_next = power_state_pkg::ST_NORMAL;
                        core_idle_next = 1'b0;
                    end
                end
                default: begin
                    state_next = power_state_pkg::ST_NORMAL;
                    core_idle_next = 1'b0;
                end
            endcase
        end
    end

    // Each state holds one code; requests outside their state fall through unchanged.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            state_reg <= power_state_pkg::STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            core_idle_reg <= 1'b0;
        end else begin
            core_idle_reg <= core_idle_next;
        end
    end

    // A halt arriving while a stop-grant is on the bus waits here, so the halt
    // announcement is never dropped behind the earlier message.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            halt_pending_reg <= 1'b0;
        end else if (!pins.power_good) begin
            halt_pending_reg <= 1'b0;
        end else if (enter_auto_halt && !(clock_halt_active && stop_grant_done_reg)) begin
            halt_pending_reg <= 1'b1;
        end else if (!cycle_reg.valid || cycle_finished) begin
            halt_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            cycle_reg <= power_state_pkg::SPECIAL_CYCLE_RESET;
        end else if (!pins.power_good) begin
            cycle_reg <= power_state_pkg::SPECIAL_CYCLE_RESET;
        end else if (halt_pending_reg && (!cycle_reg.valid || cycle_finished)) begin
            cycle_reg <= '{valid: 1'b1, message: HALT_MESSAGE};
        end else if (launch_stop_grant) begin
            cycle_reg <= '{valid: 1'b1, message: STOP_GRANT_MESSAGE};
        end else if (cycle_finished) begin
            cycle_reg <= power_state_pkg::SPECIAL_CYCLE_RESET;
        end
    end

    // The grant stays good only while the request is held; a request that drops
    // and returns costs a fresh stop-grant cycle.
    always_ff @(posedge SYS_CLK_I) begin
        if (SYS_RST_I) begin
            stop_grant_done_reg <= 1'b0;
        end else if (cycle_finished && (cycle_reg.message == STOP_GRANT_MESSAGE) &&
                     clock_halt_active && is_stop_grant_window(state_reg)) begin
            stop_grant_done_reg <= 1'b1;
        end else if (!clock_halt_active || leave_stop_grant_window || !pins.power_good) begin
            stop_grant_done_reg <= 1'b0;
        end
    end

    assign POWER_STATE_O = state_reg;
    assign CORE_IDLE_O = core_idle_reg;
    assign SPECIAL_CYCLE_VALID_O = cycle_reg.valid;
    assign SPECIAL_CYCLE_MESSAGE_O = cycle_reg.message;
    assign SNOOP_SERVICE_O = (state_reg == power_state_pkg::ST_SNOOP);
    assign INPUT_CLOCK_RUNNING_O = clock_running;

endmodule // processor_power_state_machine
`default_nettype wire

// >>> sim/platform_chipset_model.sv
// Behavioural platform chipset driving the clock-halt, deep-idle and input clock pins.
`timescale 1ns/1ps
`default_nettype none
module platform_chipset_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic want_halt_i,
    input wire logic want_deep_i,
    output logic clock_halt_request_n_o,
    output logic deep_idle_request_n_o,
    output logic input_clock_pin_o
);
    logic clock_run_reg;
    logic [2:0] settle_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_halt_request_n_o <= 1'b1;
            input_clock_pin_o <= 1'b0;
        end else begin
            clock_halt_request_n_o <= !want_halt_i;
            input_clock_pin_o <= clock_run_reg ? !input_clock_pin_o : input_clock_pin_o;
        end
    end

    // The clock stops only once the request is out, and restarts well before it is withdrawn.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            deep_idle_request_n_o <= 1'b1;
            clock_run_reg <= 1'b1;
            settle_reg <= 3'h0;
        end else if (want_deep_i) begin
            deep_idle_request_n_o <= 1'b0;
            clock_run_reg <= deep_idle_request_n_o & clock_run_reg;
            settle_reg <= 3'h0;
        end else begin
            clock_run_reg <= 1'b1;
            settle_reg <= (clock_run_reg && settle_reg != 3'h7) ? settle_reg + 3'h1 : settle_reg;
            deep_idle_request_n_o <= deep_idle_request_n_o | (settle_reg == 3'h7);
        end
    end
endmodule // platform_chipset_model
`default_nettype wire

// >>> sim/processor_power_state_machine_properties.sv
// Concurrent checks on the ports of the power state sequencer.
`timescale 1ns/1ps
`default_nettype none
module processor_power_state_machine_properties #(
    parameter int CLOCK_STOP_CYCLES = power_state_pkg::CLOCK_STOP_CYCLES
) (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic IDLE_INSTRUCTION_I,
    input wire logic SNOOP_EVENT_I,
    input wire logic SNOOP_SERVICED_I,
    input wire logic SPECIAL_CYCLE_DONE_I,
    input wire logic CLOCK_HALT_REQUEST_N_I,
    input wire logic DEEP_IDLE_REQUEST_N_I,
    input wire logic MASKABLE_IRQ_LINE_I,
    input wire logic POWER_GOOD_I,
    input wire logic [power_state_pkg::STATE_WIDTH-1:0] POWER_STATE_O,
    input wire logic CORE_IDLE_O,
    input wire logic SPECIAL_CYCLE_VALID_O,
    input wire logic [power_state_pkg::MESSAGE_WIDTH-1:0] SPECIAL_CYCLE_MESSAGE_O,
    input wire logic SNOOP_SERVICE_O,
    input wire logic INPUT_CLOCK_RUNNING_O
);
    logic st_nm, st_ah, st_qs, st_ds, st_sn;
    assign st_nm = POWER_STATE_O == power_state_pkg::ST_NORMAL;
    assign st_ah = POWER_STATE_O == power_state_pkg::ST_AUTO_HALT;
    assign st_qs = POWER_STATE_O == power_state_pkg::ST_QUICK_START;
    assign st_ds = POWER_STATE_O == power_state_pkg::ST_DEEP_SLEEP;
    assign st_sn = POWER_STATE_O == power_state_pkg::ST_SNOOP;

    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    a_state_one_hot:
    assert property ($onehot(POWER_STATE_O) && SNOOP_SERVICE_O == st_sn) else $error("bad state");
    // A done pulse one cycle back may carry Normal straight into Quick Start instead.
    a_idle_enters_halt:
    assert property (st_nm && IDLE_INSTRUCTION_I && !$past(SPECIAL_CYCLE_DONE_I)
        |=> st_ah && CORE_IDLE_O) else $error("no halt entry");
    a_break_to_normal:
    assert property (st_ah && MASKABLE_IRQ_LINE_I |-> ##[1:4] (st_nm && !CORE_IDLE_O))
        else $error("no halt break");
    a_halt_message:
    assert property ($rose(CORE_IDLE_O) |-> ##[1:20] (SPECIAL_CYCLE_VALID_O &&
        SPECIAL_CYCLE_MESSAGE_O == power_state_pkg::HALT_MESSAGE)) else $error("no halt cycle");
    a_grant_before_qs:
    assert property ($rose(st_qs) && $past(st_nm || st_ah) |-> $past(SPECIAL_CYCLE_DONE_I, 2)
        && !CLOCK_HALT_REQUEST_N_I) else $error("quick start without grant");
    a_qs_release:
    assert property ((st_qs && CLOCK_HALT_REQUEST_N_I) [*3] |=> ($past(CORE_IDLE_O) ? st_ah : st_nm))
        else $error("bad quick start exit");
    a_deep_entry:
    assert property (st_qs && !DEEP_IDLE_REQUEST_N_I && !CLOCK_HALT_REQUEST_N_I &&
        !INPUT_CLOCK_RUNNING_O |=> st_ds) else $error("no deep sleep");
    a_deep_exit:
    assert property (st_ds && DEEP_IDLE_REQUEST_N_I && INPUT_CLOCK_RUNNING_O |-> ##[1:4] st_qs)
        else $error("no deep sleep exit");
    a_snoop_entry:
    assert property ((st_ah || st_qs) && SNOOP_EVENT_I && DEEP_IDLE_REQUEST_N_I &&
        !MASKABLE_IRQ_LINE_I |=> st_sn) else $error("no snoop entry");
    a_snoop_return:
    assert property (st_sn && SNOOP_SERVICED_I |=> ($past(CORE_IDLE_O) ? st_ah : st_qs))
        else $error("bad snoop return");
    a_grant_code:
    assert property ($rose(SPECIAL_CYCLE_VALID_O) && !CORE_IDLE_O |->
        SPECIAL_CYCLE_MESSAGE_O == power_state_pkg::STOP_GRANT_MESSAGE) else $error("bad grant");
    a_cycle_holds:
    assert property (SPECIAL_CYCLE_VALID_O && !SPECIAL_CYCLE_DONE_I |=> SPECIAL_CYCLE_VALID_O
        && $stable(SPECIAL_CYCLE_MESSAGE_O)) else $error("special cycle dropped");
    a_normal_holds:
    assert property ((st_nm && CLOCK_HALT_REQUEST_N_I && !IDLE_INSTRUCTION_I && POWER_GOOD_I)
        [*3] |=> st_nm) else $error("normal left");

    c_deep: cover property (st_ds);
    c_snoop: cover property (st_sn ##1 st_ah);
    c_off: cover property (POWER_STATE_O == power_state_pkg::ST_OFF);
endmodule // processor_power_state_machine_properties
bind processor_power_state_machine processor_power_state_machine_properties #(
    .CLOCK_STOP_CYCLES(CLOCK_STOP_CYCLES)
) processor_power_state_machine_properties_inst (
    .SYS_CLK_I(SYS_CLK_I), .SYS_RST_I(SYS_RST_I), .IDLE_INSTRUCTION_I(IDLE_INSTRUCTION_I),
    .SNOOP_EVENT_I(SNOOP_EVENT_I), .SNOOP_SERVICED_I(SNOOP_SERVICED_I),
    .SPECIAL_CYCLE_DONE_I(SPECIAL_CYCLE_DONE_I), .CLOCK_HALT_REQUEST_N_I(CLOCK_HALT_REQUEST_N_I),
    .DEEP_IDLE_REQUEST_N_I(DEEP_IDLE_REQUEST_N_I), .MASKABLE_IRQ_LINE_I(MASKABLE_IRQ_LINE_I),
    .POWER_GOOD_I(POWER_GOOD_I), .POWER_STATE_O(POWER_STATE_O), .CORE_IDLE_O(CORE_IDLE_O),
    .SPECIAL_CYCLE_VALID_O(SPECIAL_CYCLE_VALID_O),
    .SPECIAL_CYCLE_MESSAGE_O(SPECIAL_CYCLE_MESSAGE_O), .SNOOP_SERVICE_O(SNOOP_SERVICE_O),
    .INPUT_CLOCK_RUNNING_O(INPUT_CLOCK_RUNNING_O)
);
`default_nettype wire

// >>> sim/processor_power_state_machine_test.sv
// Self-checking bench for the processor power state sequencer.
`timescale 1ns/1ps
`default_nettype none
module processor_power_state_machine_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic idle_in = 1'b0, snp = 1'b0, snp_done = 1'b0, cyc_done = 1'b0, mirq = 1'b0, nmi = 1'b0;
    logic smi_n = 1'b1, warm_n = 1'b1, rst_n = 1'b1, pg = 1'b1, want_halt = 1'b0, want_deep = 1'b0;
    logic chr_n, deep_n, in_clk, core_idle, valid, snoop_o, running;
    logic [power_state_pkg::STATE_WIDTH-1:0] state;
    logic [power_state_pkg::MESSAGE_WIDTH-1:0] msg;
    int miscompares = 0, n_tests = 0;

    always #5 clk = ~clk;

    platform_chipset_model platform_chipset_model_inst (.clk_i(clk), .rst_i(rst),
        .want_halt_i(want_halt), .want_deep_i(want_deep), .clock_halt_request_n_o(chr_n),
        .deep_idle_request_n_o(deep_n), .input_clock_pin_o(in_clk));
    // A short stop count keeps deep sleep entry quick.
    processor_power_state_machine #(.CLOCK_STOP_CYCLES(4)) processor_power_state_machine_inst (
        .SYS_CLK_I(clk), .SYS_RST_I(rst), .IDLE_INSTRUCTION_I(idle_in), .SNOOP_EVENT_I(snp),
        .SNOOP_SERVICED_I(snp_done), .SPECIAL_CYCLE_DONE_I(cyc_done), .CLOCK_HALT_REQUEST_N_I(chr_n),
        .DEEP_IDLE_REQUEST_N_I(deep_n), .INPUT_CLOCK_PIN_I(in_clk), .MASKABLE_IRQ_LINE_I(mirq),
        .NONMASKABLE_IRQ_I(nmi), .SYSTEM_MGMT_IRQ_N_I(smi_n), .WARM_RESTART_N_I(warm_n),
        .RESET_N_I(rst_n), .POWER_GOOD_I(pg), .POWER_STATE_O(state), .CORE_IDLE_O(core_idle),
        .SPECIAL_CYCLE_VALID_O(valid), .SPECIAL_CYCLE_MESSAGE_O(msg), .SNOOP_SERVICE_O(snoop_o),
        .INPUT_CLOCK_RUNNING_O(running));

    task automatic check(input bit ok, input string what);
        n_tests++;
        if (!ok) begin
            miscompares++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_state(input power_state_pkg::power_state_type s, input int bound);
        for (int i = 0; i < bound && state !== s; i++) tick(1);
        check(state === s, "state");
    endtask

    // Same-clock strobes are one cycle wide; the state updates on the edge that samples them.
    task automatic pulse(input int k);
        @(posedge clk);
        case (k)
            0: idle_in <= 1'b1;
            1: snp <= 1'b1;
            2: snp_done <= 1'b1;
            default: cyc_done <= 1'b1;
        endcase
        @(posedge clk);
        {idle_in, snp, snp_done, cyc_done} <= 4'h0;
        #1;
    endtask

    task automatic serve_cycle(input logic [power_state_pkg::MESSAGE_WIDTH-1:0] m);
        for (int i = 0; i < 10 && valid !== 1'b1; i++) tick(1);
        check(valid === 1'b1 && msg === m, "special cycle");
        pulse(3);
        check(valid === 1'b0, "cycle release");
    endtask

    task automatic set_break(input int k, input logic on);
        @(posedge clk);
        case (k)
            0: mirq <= on;
            1: nmi <= on;
            2: smi_n <= !on;
            3: warm_n <= !on;
            default: rst_n <= !on;
        endcase
    endtask

    task automatic t_reset;
        check(state === power_state_pkg::ST_NORMAL && core_idle === 1'b0, "reset");
        check(valid === 1'b0 && running === 1'b1, "reset outputs");
        @(posedge clk);
        pg <= 1'b0;
        wait_state(power_state_pkg::ST_OFF, 6);
        @(posedge clk);
        pg <= 1'b1;
        wait_state(power_state_pkg::ST_NORMAL, 6);
        $display("t_reset done");
    endtask

    task automatic t_halt_break;
        for (int k = 0; k < 5; k++) begin
            pulse(0);
            check(state === power_state_pkg::ST_AUTO_HALT && core_idle === 1'b1, "halt");
            serve_cycle(power_state_pkg::HALT_MESSAGE);
            set_break(k, 1'b1);
            wait_state(power_state_pkg::ST_NORMAL, 6);
            check(core_idle === 1'b0, "idle clear");
            set_break(k, 1'b0);
            tick(4);
        end
        $display("t_halt_break done");
    endtask

    task automatic t_quick;
        @(posedge clk);
        want_halt <= 1'b1;
        tick(8);
        check(state === power_state_pkg::ST_NORMAL && valid === 1'b1, "grant pending");
        serve_cycle(power_state_pkg::STOP_GRANT_MESSAGE);
        wait_state(power_state_pkg::ST_QUICK_START, 3);
        pulse(0);
        check(state === power_state_pkg::ST_QUICK_START, "idle ignored");
        pulse(1);
        check(state === power_state_pkg::ST_SNOOP && snoop_o === 1'b1, "snoop");
        pulse(2);
        check(state === power_state_pkg::ST_QUICK_START, "snoop back");
        @(posedge clk);
        want_deep <= 1'b1;
        wait_state(power_state_pkg::ST_DEEP_SLEEP, 40);
        @(posedge clk);
        want_deep <= 1'b0;
        wait_state(power_state_pkg::ST_QUICK_START, 40);
        @(posedge clk);
        want_halt <= 1'b0;
        wait_state(power_state_pkg::ST_NORMAL, 6);
        $display("t_quick done");
    endtask

    task automatic t_snoop_halt;
        pulse(0);
        serve_cycle(power_state_pkg::HALT_MESSAGE);
        pulse(1);
        check(state === power_state_pkg::ST_SNOOP, "snoop");
        pulse(2);
        check(state === power_state_pkg::ST_AUTO_HALT, "snoop to halt");
        @(posedge clk);
        want_halt <= 1'b1;
        serve_cycle(power_state_pkg::STOP_GRANT_MESSAGE);
        wait_state(power_state_pkg::ST_QUICK_START, 3);
        @(posedge clk);
        want_halt <= 1'b0;
        wait_state(power_state_pkg::ST_AUTO_HALT, 6);
        set_break(0, 1'b1);
        wait_state(power_state_pkg::ST_NORMAL, 6);
        set_break(0, 1'b0);
        $display("t_snoop_halt done");
    endtask

    task automatic t_ignore;
        @(posedge clk);
        want_deep <= 1'b1;
        tick(20);
        check(state === power_state_pkg::ST_NORMAL && running === 1'b0, "deep ignored");
        @(posedge clk);
        want_deep <= 1'b0;
        tick(20);
        check(state === power_state_pkg::ST_NORMAL && running === 1'b1, "still normal");
        $display("t_ignore done");
    endtask

    task automatic stop_test;
        $display("Checks %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tick(4);
        t_reset();
        t_halt_break();
        t_quick();
        t_snoop_halt();
        t_ignore();
        stop_test();
    end
endmodule // processor_power_state_machine_test
`default_nettype wire
